// ==== core/fbm_regs.svh ====
`ifndef FBM_REGS_SVH
`define FBM_REGS_SVH

// register offsets on the plain port
`define FBM_OFF_FLASH_CTRL 4'h0
`define FBM_OFF_STATUS 4'h1
`define FBM_OFF_SERIAL_CTRL 4'h2
`define FBM_OFF_BIT_RATE 4'h3
`define FBM_OFF_PORT_DIR 4'h4
`define FBM_OFF_PORT_DATA 4'h5
`define FBM_OFF_LOADER_CTRL 4'h6
`define FBM_OFF_MEASURE 4'h7

// flash control bits
`define FBM_FC_PROG 0
`define FBM_FC_ERASE 1
`define FBM_FC_PVER 2
`define FBM_FC_EVER 3

// serial control bits
`define FBM_SC_RXEN 4
`define FBM_SC_TXEN 5

// loader control bits
`define FBM_LC_DONE 0
`define FBM_LC_ERASE_FAIL 1
`define FBM_LC_HANDOVER 2

// port bit of the transmit pin
`define FBM_TX_BIT 2

// reset values
`define FBM_RST_SERIAL_CTRL 8'h00
`define FBM_RST_BIT_RATE 8'hff
`define FBM_RST_PORT_DIR 8'h00
`define FBM_RST_PORT_DATA 8'h00

// byte codes
`define FBM_ERASED_BYTE 8'hff
`define FBM_SYNC_BYTE 8'h00
`define FBM_PATTERN_BYTE 8'h55
`define FBM_ERROR_BYTE 8'hff

// timing
`define FBM_CLK_MHZ 50
`define FBM_START_STATES 100
`define FBM_START_CYCLES (`FBM_START_STATES)

// flash geometry
`define FBM_FLASH_AW 15
`define FBM_FLASH_LAST 15'h7fff

`endif

// ==== core/fbm_pkg.sv ====
package fbm_pkg;

	typedef enum logic [3:0] {
		FBM_IDLE = 4'h0,
		FBM_WAIT_START = 4'h1,
		FBM_MEASURE = 4'h3,
		FBM_SEND_SYNC = 4'h2,
		FBM_WAIT_PATTERN = 4'h6,
		FBM_BLANK_CHECK = 4'h7,
		FBM_ERASE = 4'h5,
		FBM_LOADING = 4'h4,
		FBM_HANDOVER = 4'hc,
		FBM_HALT = 4'hd
	} fbm_state_t;

	typedef enum logic [2:0] {
		FBM_MODE_READ = 3'h0,
		FBM_MODE_PROGRAM = 3'h1,
		FBM_MODE_ERASE = 3'h2,
		FBM_MODE_PVERIFY = 3'h3,
		FBM_MODE_EVERIFY = 3'h4,
		FBM_MODE_PREWRITE = 3'h5
	} fbm_mode_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} fbm_bus_t;

	typedef struct packed {
		logic [7:0] data;
		logic valid;
	} fbm_byte_t;

	typedef struct packed {
		fbm_state_t state;
		logic boot_latched;
		logic user_mode;
		logic [7:0] wait_cnt;
		logic [15:0] low_cnt;
		logic [15:0] measure;
		logic [3:0] flash_ctrl;
		logic [7:0] serial_ctrl;
		logic [7:0] bit_rate;
		logic [7:0] port_dir;
		logic [7:0] port_data;
		logic [14:0] flash_addr;
		logic dirty;
		logic erase_fail;
		logic done;
		logic [7:0] rdata;
		logic [7:0] tx_data;
		logic tx_valid;
		logic [2:0] rx_sync;
		logic rx_level;
		logic [2:0] test_sync;
		logic test_level;
		logic [2:0] supply_sync;
		logic supply_level;
	} fbm_state_reg_t;

endpackage

// ==== core/fbm_boot_ctrl.sv ====
`timescale 1ns/100ps
`include "fbm_regs.svh"

// Behaviour
// (RL1) host holds receive line high when reset releases into boot mode
// (RL2) wait about 100 states after release before measuring low periods
// (RL3) if any flash byte is not all-ones, erase every block first
// (RL4) interrupts are blocked while programming or erasing
// (RL5) before handover clear receive and transmit enables, keep bit rate
// (RL6) at handover transmit pin is an output driving high
// (RL7) downloaded program initialises its general registers and stack
// (RL8) all other registers keep their initial values at handover
// (RL9) at reset release, both mode pins high latches boot mode
// (RL10) host leaves boot mode via reset, pins low ten clocks later
// (RL11) host holds external pin settings during boot execution
// (RL12) boot latch drops when test pin high level goes away
// (RL13) watchdog reset restarts the loader, keeping the boot latch
// (RL14) test pin change during reset changes mode and port states; here only BOOT_MODE follows it, port registers stay at reset values
// (RL15) host raises supply pin only when flash is idle
// (RL16) flash reads not serviced while program or erase is active
// (RL17) five flash modes chosen by four flash control bits
// (RL18) after measuring send one zero byte, then wait for 0x55
// (RL19) host sends length high byte first then program, echoed back
// (RL20) erase failure sends one all-ones byte and halts
// (RL21) boot latch cleared only by external reset or test pin loss
module fbm_boot_ctrl
	import fbm_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic WDT_RESET,
	input wire logic TEST_HIGH,
	input wire logic SUPPLY_HIGH,
	input wire logic RX_PIN,
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	output logic [14:0] FLASH_ADDR,
	input wire logic [7:0] FLASH_RDATA,
	input wire logic FLASH_RD_REQ,
	output logic FLASH_RD_GRANT,
	output logic ERASE_START,
	input wire logic ERASE_DONE,
	input wire logic ERASE_FAIL,
	output logic [7:0] TX_DATA,
	output logic TX_VALID,
	input wire logic TX_READY,
	input wire logic [7:0] RX_DATA,
	input wire logic RX_VALID,
	output logic BOOT_MODE,
	output logic USER_MODE,
	output logic [2:0] FLASH_MODE,
	output logic IRQ_BLOCK,
	output logic PORT_TX_DIR,
	output logic PORT_TX_DATA,
	output logic HANDOVER
);

	fbm_state_reg_t s_reg;
	fbm_state_reg_t s_next;
	fbm_bus_t bus;
	logic busy;
	logic rx_low;
	logic [7:0] rd_val;

	assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
	// program or erase bit set means the array is busy
	assign busy = s_reg.flash_ctrl[`FBM_FC_PROG] |
		s_reg.flash_ctrl[`FBM_FC_ERASE];
	assign rx_low = ~s_reg.rx_level;

	always_comb begin
		rd_val = 8'h00;
		case (bus.addr)
			`FBM_OFF_FLASH_CTRL: rd_val = {4'h0, s_reg.flash_ctrl};
			`FBM_OFF_STATUS: rd_val = {3'h0, s_reg.state, s_reg.boot_latched};
			`FBM_OFF_SERIAL_CTRL: rd_val = s_reg.serial_ctrl;
			`FBM_OFF_BIT_RATE: rd_val = s_reg.bit_rate;
			`FBM_OFF_PORT_DIR: rd_val = s_reg.port_dir;
			`FBM_OFF_PORT_DATA: rd_val = s_reg.port_data;
			`FBM_OFF_LOADER_CTRL: rd_val = {5'h00, s_reg.state == FBM_HANDOVER,
				s_reg.erase_fail, s_reg.done};
			`FBM_OFF_MEASURE: rd_val = s_reg.measure[7:0];
			default: rd_val = 8'h00;
		endcase
	end

	always_comb begin
		s_next = s_reg;
		s_next.tx_valid = s_reg.tx_valid & ~TX_READY;
		// three-stage sampling, a change counts when stages two and three agree
		s_next.rx_sync = {s_reg.rx_sync[1:0], RX_PIN};
		if (s_reg.rx_sync[2] == s_reg.rx_sync[1])
			s_next.rx_level = s_reg.rx_sync[2];
		s_next.test_sync = {s_reg.test_sync[1:0], TEST_HIGH};
		if (s_reg.test_sync[2] == s_reg.test_sync[1])
			s_next.test_level = s_reg.test_sync[2];
		// supply pin is asynchronous too, so it is filtered like the others
		s_next.supply_sync = {s_reg.supply_sync[1:0], SUPPLY_HIGH};
		if (s_reg.supply_sync[2] == s_reg.supply_sync[1])
			s_next.supply_level = s_reg.supply_sync[2];
		if (s_reg.state != FBM_IDLE && !s_next.test_level)
			s_next.boot_latched = 1'b0; // see (RL12) see (RL21)
		s_next.user_mode = s_next.supply_level & ~s_next.test_level & ~busy;
		if (bus.rd)
			s_next.rdata = rd_val;
		if (bus.wr) begin
			case (bus.addr)
				`FBM_OFF_FLASH_CTRL: s_next.flash_ctrl = bus.wdata[3:0]; // see (RL17)
				`FBM_OFF_SERIAL_CTRL: s_next.serial_ctrl = bus.wdata;
				`FBM_OFF_BIT_RATE: s_next.bit_rate = bus.wdata;
				`FBM_OFF_PORT_DIR: s_next.port_dir = bus.wdata;
				`FBM_OFF_PORT_DATA: s_next.port_data = bus.wdata;
				default: s_next.flash_ctrl = s_next.flash_ctrl;
			endcase
		end
		case (s_reg.state)
			FBM_IDLE: begin
				// every cycle in idle, from reset release on: sample both mode pins
				if (TEST_HIGH && SUPPLY_HIGH && !s_reg.boot_latched) begin
					s_next.boot_latched = 1'b1; // see (RL9)
					s_next.test_level = 1'b1;
					s_next.test_sync = 3'h7;
				end
				if ((TEST_HIGH && SUPPLY_HIGH) || s_reg.boot_latched) begin
					s_next.state = FBM_WAIT_START;
					s_next.wait_cnt = 8'h00;
				end
			end
			FBM_WAIT_START: begin
				// receive line edges before this point are ignored
				s_next.wait_cnt = s_reg.wait_cnt + 8'h01;
				if (s_reg.wait_cnt == 8'(`FBM_START_CYCLES - 1)) begin
					s_next.state = FBM_MEASURE; // see (RL2)
					s_next.low_cnt = 16'h0000;
				end
			end
			FBM_MEASURE: begin
				if (rx_low) begin
					s_next.low_cnt = s_reg.low_cnt + 16'h0001;
				end else if (s_reg.low_cnt != 16'h0000) begin
					// low run covers start bit plus eight zero data bits
					s_next.measure = s_reg.low_cnt;
					s_next.bit_rate = s_reg.low_cnt[15:8];
					s_next.state = FBM_SEND_SYNC;
				end
			end
			FBM_SEND_SYNC: begin
				if (!s_reg.tx_valid) begin
					s_next.tx_data = `FBM_SYNC_BYTE; // see (RL18)
					s_next.tx_valid = 1'b1;
					s_next.state = FBM_WAIT_PATTERN;
				end
			end
			FBM_WAIT_PATTERN: begin
				// other bytes are dropped; the host retries by reset
				if (RX_VALID && RX_DATA == `FBM_PATTERN_BYTE) begin
					s_next.state = FBM_BLANK_CHECK; // see (RL18)
					s_next.flash_addr = 15'h0000;
					s_next.dirty = 1'b0;
				end
			end
			FBM_BLANK_CHECK: begin
				if (FLASH_RDATA != `FBM_ERASED_BYTE)
					s_next.dirty = 1'b1; // see (RL3)
				s_next.flash_addr = s_reg.flash_addr + 15'h0001;
				if (s_reg.flash_addr == `FBM_FLASH_LAST)
					s_next.state = (s_next.dirty) ? FBM_ERASE : FBM_LOADING;
			end
			FBM_ERASE: begin
				s_next.flash_ctrl = 4'h0;
				s_next.flash_ctrl[`FBM_FC_ERASE] = 1'b1;
				if (ERASE_FAIL) begin
					s_next.flash_ctrl = 4'h0;
					s_next.erase_fail = 1'b1;
					s_next.tx_data = `FBM_ERROR_BYTE; // see (RL20)
					s_next.tx_valid = 1'b1;
					s_next.state = FBM_HALT;
				end else if (ERASE_DONE) begin
					s_next.flash_ctrl = 4'h0;
					s_next.state = FBM_LOADING;
				end
			end
			FBM_LOADING: begin
				// software runs the download and echo, then signals done
				if (bus.wr && bus.addr == `FBM_OFF_LOADER_CTRL &&
					bus.wdata[`FBM_LC_DONE]) begin
					s_next.done = 1'b1;
					// stop serial, bit rate stays as measured
					s_next.serial_ctrl[`FBM_SC_RXEN] = 1'b0; // see (RL5)
					s_next.serial_ctrl[`FBM_SC_TXEN] = 1'b0; // see (RL5)
					s_next.port_dir[`FBM_TX_BIT] = 1'b1; // see (RL6)
					s_next.port_data[`FBM_TX_BIT] = 1'b1; // see (RL6)
					s_next.state = FBM_HANDOVER; // see (RL8)
				end
			end
			FBM_HANDOVER: s_next.state = FBM_HANDOVER;
			FBM_HALT: s_next.state = FBM_HALT; // see (RL20)
			default: s_next.state = FBM_IDLE;
		endcase
		if (WDT_RESET) begin
			// restart the loader but keep the latched mode
			s_next.state = FBM_IDLE; // see (RL13) see (RL21)
			s_next.flash_ctrl = 4'h0;
			s_next.done = 1'b0;
			s_next.erase_fail = 1'b0;
			s_next.tx_valid = 1'b0;
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			s_reg <= '0;
			s_reg.state <= FBM_IDLE;
			s_reg.serial_ctrl <= `FBM_RST_SERIAL_CTRL;
			s_reg.bit_rate <= `FBM_RST_BIT_RATE;
			s_reg.port_dir <= `FBM_RST_PORT_DIR;
			s_reg.port_data <= `FBM_RST_PORT_DATA;
			s_reg.rx_sync <= 3'h7;
			s_reg.rx_level <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	always_comb begin
		FLASH_MODE = FBM_MODE_READ;
		case (s_reg.flash_ctrl)
			4'h1: FLASH_MODE = FBM_MODE_PROGRAM; // see (RL17)
			4'h2: FLASH_MODE = FBM_MODE_ERASE;
			4'h4: FLASH_MODE = FBM_MODE_PVERIFY;
			4'h8: FLASH_MODE = FBM_MODE_EVERIFY;
			4'hc: FLASH_MODE = FBM_MODE_PREWRITE;
			default: FLASH_MODE = FBM_MODE_READ;
		endcase
	end

	assign RDATA = s_reg.rdata;
	assign FLASH_ADDR = s_reg.flash_addr;
	assign FLASH_RD_GRANT = FLASH_RD_REQ & ~busy; // see (RL16)
	assign IRQ_BLOCK = busy; // see (RL4)
	assign ERASE_START = (s_reg.state == FBM_ERASE);
	assign TX_DATA = s_reg.tx_data;
	assign TX_VALID = s_reg.tx_valid;
	// during reset the mode follows both mode pins directly
	assign BOOT_MODE = RST ? (TEST_HIGH & SUPPLY_HIGH) : s_reg.boot_latched; // see (RL14)
	assign USER_MODE = s_reg.user_mode;
	assign PORT_TX_DIR = s_reg.port_dir[`FBM_TX_BIT];
	assign PORT_TX_DATA = s_reg.port_data[`FBM_TX_BIT];
	assign HANDOVER = (s_reg.state == FBM_HANDOVER);

endmodule // fbm_boot_ctrl

// ==== verif/fbm_boot_ctrl_monitor.sv ====
`timescale 1ns/100ps
module fbm_boot_monitor
	import fbm_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic WDT_RESET,
	input wire logic TEST_HIGH,
	input wire logic SUPPLY_HIGH,
	input wire logic FLASH_RD_GRANT,
	input wire logic ERASE_START,
	input wire logic ERASE_FAIL,
	input wire logic [7:0] TX_DATA,
	input wire logic TX_VALID,
	input wire logic BOOT_MODE,
	input wire logic [2:0] FLASH_MODE,
	input wire logic IRQ_BLOCK,
	input wire logic PORT_TX_DIR,
	input wire logic PORT_TX_DATA,
	input wire logic HANDOVER
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);
	// loader age, restarted by either reset
	logic [7:0] age_reg;
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST)
			age_reg <= 8'h00;
		else if (WDT_RESET)
			age_reg <= 8'h00;
		else if (age_reg != 8'hff)
			age_reg <= age_reg + 8'h01;
	end
	chk_start_delay: assert property (
		$rose(TX_VALID) |-> age_reg > 8'h64) else $error("early sync");
	chk_boot_latch: assert property (
		$fell(RST) |=> BOOT_MODE == $past(TEST_HIGH && SUPPLY_HIGH))
		else $error("latch");
	chk_wdt_keep: assert property (
		WDT_RESET && BOOT_MODE && TEST_HIGH |=> BOOT_MODE) else $error("wdt");
	chk_test_drop: assert property (
		BOOT_MODE && $fell(TEST_HIGH) |-> ##[1:5] !BOOT_MODE)
		else $error("test drop");
	chk_irq_block: assert property (
		FLASH_MODE inside {FBM_MODE_PROGRAM, FBM_MODE_ERASE} |-> IRQ_BLOCK)
		else $error("irq");
	chk_read_hold: assert property (
		IRQ_BLOCK |-> !FLASH_RD_GRANT) else $error("grant");
	chk_tx_pin: assert property (
		$rose(HANDOVER) |-> ##[0:1] PORT_TX_DIR && PORT_TX_DATA)
		else $error("tx pin");
	chk_erase_error: assert property (
		ERASE_START && ERASE_FAIL |-> ##[1:3] TX_VALID && TX_DATA == 8'hff)
		else $error("error byte");
	cov_wdt: cover property (WDT_RESET && BOOT_MODE);
	cov_handover: cover property ($rose(HANDOVER));
	cov_erase_fail: cover property (ERASE_START && ERASE_FAIL);
endmodule // fbm_boot_monitor

bind fbm_boot_ctrl fbm_boot_monitor i_mon (.CLOCK, .RST, .WDT_RESET,
	.TEST_HIGH, .SUPPLY_HIGH, .FLASH_RD_GRANT, .ERASE_START, .ERASE_FAIL,
	.TX_DATA, .TX_VALID, .BOOT_MODE, .FLASH_MODE, .IRQ_BLOCK,
	.PORT_TX_DIR, .PORT_TX_DATA, .HANDOVER);

// ==== verif/fbm_host_model.sv ====
`timescale 1ns/100ps
module fbm_host_model (
	input wire logic CLOCK,
	input wire logic RESTART,
	input wire logic [15:0] LOW_LEN,
	input wire logic [7:0] TX_DATA,
	input wire logic TX_VALID,
	output logic TX_READY = 1'b0,
	output logic [7:0] RX_DATA = 8'h00,
	output logic RX_VALID = 1'b0,
	output logic RX_PIN = 1'b1
);
	logic [15:0] t = 16'h0000;
	logic [3:0] ans = 4'h0;
	always @(posedge CLOCK) begin
		t <= RESTART ? 16'h0000 : t + {15'h0000, t != 16'hffff};
		// early pulse lands inside the start-up delay and must not count
		RX_PIN <= !((t > 16'h0013 && t < 16'h003c) ||
			(t > 16'h00c7 && t < 16'h00c8 + LOW_LEN));
		TX_READY <= 1'($urandom);
		RX_VALID <= ans == 4'h9 || ans == 4'h5 || ans == 4'h1;
		// pattern, then length high byte first; idle bytes scrambled
		RX_DATA <= ans == 4'h9 ? 8'h55 :
			ans == 4'h5 ? 8'h00 : ans == 4'h1 ? 8'h10 : 8'($urandom);
		if (ans != 4'h0)
			ans <= ans - 4'h1;
		if (TX_VALID && TX_READY && TX_DATA == 8'h00)
			ans <= 4'hd;
		if (RESTART)
			ans <= 4'h0;
	end
endmodule // fbm_host_model

// ==== verif/testbench.sv ====
`timescale 1ns/100ps
module testbench
	import fbm_pkg::*;
;
	logic CLOCK = 1'b0, RST = 1'b1, WDT_RESET = 1'b0, TEST_HIGH = 1'b1;
	logic SUPPLY_HIGH = 1'b1, WR = 1'b0, RD = 1'b0, FLASH_RD_REQ = 1'b0;
	logic ERASE_DONE = 1'b0, ERASE_FAIL = 1'b0, dirty = 1'b0, rd_d = 1'b0;
	logic [3:0] ADDR = 4'h0;
	logic [7:0] WDATA = 8'h00, RDATA, TX_DATA, RX_DATA, FLASH_RDATA;
	logic [15:0] low_len = 16'h0280;
	logic [14:0] FLASH_ADDR;
	logic [2:0] FLASH_MODE;
	logic RX_PIN, FLASH_RD_GRANT, ERASE_START, TX_VALID, TX_READY, RX_VALID;
	logic BOOT_MODE, USER_MODE, IRQ_BLOCK, PORT_TX_DIR, PORT_TX_DATA, HANDOVER;
	logic [3:0] fc[6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hc, 4'h0};
	fbm_mode_t fm[6] = '{FBM_MODE_PROGRAM, FBM_MODE_ERASE, FBM_MODE_PVERIFY,
		FBM_MODE_EVERIFY, FBM_MODE_PREWRITE, FBM_MODE_READ};
	logic [7:0] rd_q[$], tx_q[$];
	int bad_count = 0, check_count = 0, n;

	fbm_boot_ctrl i_dut (.CLOCK, .RST, .WDT_RESET, .TEST_HIGH, .SUPPLY_HIGH,
		.RX_PIN, .ADDR, .WDATA, .WR, .RD, .RDATA, .FLASH_ADDR, .FLASH_RDATA,
		.FLASH_RD_REQ, .FLASH_RD_GRANT, .ERASE_START, .ERASE_DONE,
		.ERASE_FAIL, .TX_DATA, .TX_VALID, .TX_READY, .RX_DATA, .RX_VALID,
		.BOOT_MODE, .USER_MODE, .FLASH_MODE, .IRQ_BLOCK, .PORT_TX_DIR,
		.PORT_TX_DATA, .HANDOVER);
	fbm_host_model i_host (.CLOCK, .RESTART(RST || WDT_RESET),
		.LOW_LEN(low_len), .TX_DATA, .TX_VALID, .TX_READY, .RX_DATA,
		.RX_VALID, .RX_PIN);

	task automatic check(input logic [7:0] s, e);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, s, e);
		end
	endtask
	task automatic conclude;
		if (bad_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic acc(input logic w, input logic [3:0] a,
		input logic [7:0] d);
		ADDR <= a;
		WDATA <= d;
		WR <= w;
		RD <= !w;
		if (!w)
			rd_q.push_back(d);
		@(posedge CLOCK);
		WR <= 1'b0;
		RD <= 1'b0;
		@(posedge CLOCK);
	endtask
	task automatic boot(input logic f);
		RST <= 1'b1;
		dirty <= f;
		SUPPLY_HIGH <= 1'b1;
		TEST_HIGH <= 1'b0;
		low_len <= {8'h02 + 8'($urandom % 4), 8'h80};
		repeat (2) @(posedge CLOCK);
		check(BOOT_MODE, 1'b0);
		TEST_HIGH <= 1'b1;
		repeat (2) @(posedge CLOCK);
		check(BOOT_MODE, 1'b1);
		tx_q.push_back(8'h00);
		RST <= 1'b0;
		repeat (50) @(posedge CLOCK);
		WDT_RESET <= 1'b1;
		@(posedge CLOCK);
		WDT_RESET <= 1'b0;
		@(posedge CLOCK);
		check(BOOT_MODE, 1'b1);
		for (n = 0; n < 5000 && !RX_VALID; n++)
			@(posedge CLOCK);
		check(RX_VALID, 1'b1);
	endtask

	// only the last address is dirty, so a short blank check misses it
	assign FLASH_RDATA = (dirty && FLASH_ADDR == 15'h7fff) ? 8'h3c : 8'hff;
	always #10 CLOCK = !CLOCK;
	always @(posedge CLOCK) begin
		ERASE_FAIL <= ERASE_START && !ERASE_FAIL;
		rd_d <= RD;
		if (rd_d)
			check(RDATA, rd_q.pop_front());
		if (TX_VALID && TX_READY)
			check(TX_DATA, tx_q.size() ? tx_q.pop_front() : 8'hxx);
	end

	initial begin
		void'($urandom(77));
		boot(1'b0);
		repeat (33000) @(posedge CLOCK);
		acc(1'b0, 4'h1, {3'h0, FBM_LOADING, 1'b1});
		acc(1'b0, 4'h4, 8'h00);
		acc(1'b1, 4'h2, 8'h31);
		acc(1'b1, 4'h5, 8'h81);
		acc(1'b1, 4'h9, 8'h5a);
		acc(1'b0, 4'h9, 8'h00);
		acc(1'b0, 4'h2, 8'h31);
		acc(1'b1, 4'h6, 8'h01);
		@(posedge CLOCK);
		check(HANDOVER, 1'b1);
		check(PORT_TX_DIR && PORT_TX_DATA, 1'b1);
		// clear flash control, then check the registers kept at handover: enables cleared, bit rate kept, transmit pin high
		acc(1'b1, 4'h0, 8'h00);
		acc(1'b0, 4'h2, 8'h01);
		acc(1'b0, 4'h3, low_len[15:8]);
		acc(1'b0, 4'h4, 8'h04);
		acc(1'b0, 4'h5, 8'h85);
		RST <= 1'b1;
		repeat (10) @(posedge CLOCK);
		TEST_HIGH <= 1'b0;
		SUPPLY_HIGH <= 1'b0;
		@(posedge CLOCK);
		RST <= 1'b0;
		repeat (3) @(posedge CLOCK);
		check(BOOT_MODE, 1'b0);
		SUPPLY_HIGH <= 1'b1;
		FLASH_RD_REQ <= 1'b1;
		repeat (6) @(posedge CLOCK);
		check(USER_MODE, 1'b1);
		foreach (fc[i]) begin
			acc(1'b1, 4'h0, {4'h0, fc[i]});
			check(FLASH_MODE, fm[i]);
			check(IRQ_BLOCK, |fc[i][1:0]);
			check(FLASH_RD_GRANT, ~|fc[i][1:0]);
		end
		boot(1'b1);
		tx_q.push_back(8'hff);
		for (n = 0; n < 34000 && !ERASE_START; n++)
			@(posedge CLOCK);
		check(ERASE_START, 1'b1);
		repeat (20) @(posedge CLOCK);
		acc(1'b0, 4'h1, {3'h0, FBM_HALT, 1'b1});
		TEST_HIGH <= 1'b0;
		repeat (8) @(posedge CLOCK);
		check(BOOT_MODE, 1'b0);
		conclude();
	end
	initial begin
		repeat (90000) @(posedge CLOCK);
		bad_count++;
		conclude();
	end
endmodule // testbench
